// ===== include/psms_pkg.sv
// shared constants, types and arithmetic for the pump speed-mode sequencer
package psms_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int SPEED_W = 16; // speed values in rpm
  localparam int PM_W = 10; // setpoints in tenths of a percent

  // ****************************************************************
  // speed figures
  // ****************************************************************
  localparam logic [PM_W-1:0] PM_FULL = 10'h3e8; // 100.0 percent
  localparam logic [PM_W-1:0] PM_MIN = 10'h0fa; // 25.0 percent
  localparam logic [PM_W-1:0] PM_AT_SPEED = 10'h320; // 80.0 percent
  localparam logic [SPEED_W-1:0] STOP_RPM = 16'h003c; // 60 rpm, rotation ends
  localparam logic [SPEED_W-1:0] RATED_RPM_RST = 16'h7530; // rated speed after reset
  localparam logic [PM_W-1:0] SETPOINT_RST = 10'h1f4; // reduced setpoint after reset

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_FREQ_HZ = 125_000_000; // hclk rate
  localparam int SPIN_DELAY_MS = 2000; // acceleration to rotation flag
  localparam int SPIN_DELAY_CYC = SPIN_DELAY_MS * (CLK_FREQ_HZ / 1000);

  // ****************************************************************
  // register map and fields
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00; // mode control, read/write
  localparam logic [7:0] REG_CMD = 8'h04; // start/stop pulses, write only
  localparam logic [7:0] REG_SETPOINT = 8'h08; // reduced setpoint, read/write
  localparam logic [7:0] REG_RATED = 8'h0c; // rated speed, read/write
  localparam logic [7:0] REG_STATUS = 8'h10; // sequencer state, read only
  localparam logic [7:0] REG_SPEED = 8'h14; // measured speed, read only
  localparam int CTRL_LOCAL_BIT = 0;
  localparam int CTRL_REDUCED_BIT = 1;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {ST_IDLE, ST_ACCEL, ST_HOLD, ST_DECEL, ST_STOPPING} psms_state_e;
  typedef enum logic [1:0] {DISP_STOP, DISP_ACC, DISP_NORMAL, DISP_BRAKE} psms_disp_e;

  // value scaled by a setpoint in tenths of a percent
  function automatic logic [SPEED_W-1:0] psms_pct_of(input logic [SPEED_W-1:0] value,
                                                      input logic [PM_W-1:0] pm);
    logic [SPEED_W+PM_W-1:0] prod;
    prod = value * pm;
    return SPEED_W'(prod / 26'h00003e8);
  endfunction

endpackage

// ===== verilog/psms_target.sv
// active target and at-speed threshold for the pump speed-mode sequencer
`timescale 1ns/100ps
module psms_target
  import psms_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [psms_pkg::SPEED_W-1:0] rated_rpm,
  input wire logic [psms_pkg::PM_W-1:0] setpoint,
  input wire logic reduced_sel,
  output logic [psms_pkg::SPEED_W-1:0] reduced_rpm,
  output logic [psms_pkg::SPEED_W-1:0] target_rpm,
  output logic [psms_pkg::SPEED_W-1:0] thr_rpm,
  output logic reduced_above80,
  output logic target_moved
);
  import psms_pkg::*;

  // ****************************************************************
  // combinational targets
  // ****************************************************************
  wire [SPEED_W-1:0] next_reduced_rpm = psms_pct_of(rated_rpm, setpoint);
  wire [SPEED_W-1:0] next_target_rpm = reduced_sel ? next_reduced_rpm : rated_rpm;

  // ****************************************************************
  // registered targets
  // ****************************************************************
  // threshold follows target
  // threshold is taken from the next target, so it changes with target_rpm in the same cycle;
  // target_moved marks the first cycle of a new target for the sequencer to wait out
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reduced_rpm <= '0;
      target_rpm <= '0;
      thr_rpm <= '0;
      reduced_above80 <= 1'b0;
      target_moved <= 1'b0;
    end
    else
    begin
      reduced_rpm <= next_reduced_rpm;
      target_rpm <= next_target_rpm;
      thr_rpm <= psms_pct_of(next_target_rpm, PM_AT_SPEED);
      reduced_above80 <= setpoint > PM_AT_SPEED;
      target_moved <= next_target_rpm != target_rpm;
    end
  end

endmodule // psms_target

// ===== verilog/psms_sequencer.sv
// pump speed-mode sequencer with its ahb-lite register slave
`timescale 1ns/100ps
module psms_sequencer
  import psms_pkg::*;
#(
  parameter int SPIN_DELAY = psms_pkg::SPIN_DELAY_CYC // cycles from start to rotation flag
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [psms_pkg::SPEED_W-1:0] measured_speed,
  input wire logic remote_start,
  input wire logic remote_stop,
  input wire logic remote_reduced_select,
  output logic speeding_up_output,
  output logic slowing_output,
  output logic at_speed_output,
  output logic spinning_output,
  output logic at_speed_lamp,
  output logic speed_changing_marker,
  output logic speeding_up_display,
  output psms_pkg::psms_disp_e op_display,
  output logic motor_accel,
  output logic motor_brake
);
  import psms_pkg::*;

  localparam logic [31:0] SPIN_LAST = 32'(SPIN_DELAY - 1); // last count before flag

  // ****************************************************************
  // ahb-lite register slave
  // ****************************************************************
  logic wr_pend; // write data phase pending
  logic [7:0] wr_addr; // captured write offset
  logic [1:0] ctrl; // local mode and local reduced select
  logic [PM_W-1:0] setpoint; // reduced setpoint, tenths of a percent
  logic [SPEED_W-1:0] rated_rpm; // rated speed
  logic cmd_start; // one-cycle start from software
  logic cmd_stop; // one-cycle stop from software
  psms_state_e state; // sequencer state
  psms_state_e next_state;
  logic [SPEED_W-1:0] spd_q; // registered measured speed

  wire addr_ok = hsel & hready & htrans[1]; // nonseq or seq taken
  wire wr_take = addr_ok & hwrite & (hsize == HSIZE_WORD); // narrow writes ignored
  wire rd_take = addr_ok & ~hwrite;
  wire wr_ctrl = wr_pend & (wr_addr == REG_CTRL);
  wire wr_cmd = wr_pend & (wr_addr == REG_CMD);
  wire wr_setpoint = wr_pend & (wr_addr == REG_SETPOINT);
  wire wr_rated = wr_pend & (wr_addr == REG_RATED);
  wire [PM_W-1:0] wr_pm = hwdata[PM_W-1:0];
  wire pm_ok = (hwdata[31:PM_W] == '0) & (wr_pm >= PM_MIN) & (wr_pm <= PM_FULL);
  wire [31:0] status_word = {20'h00000, 1'b0, state, slowing_output, speeding_up_output,
                             at_speed_output, spinning_output, motor_brake, motor_accel,
                             speed_changing_marker, ctrl[CTRL_LOCAL_BIT]};
  wire [7:0] rd_addr = haddr[7:0];
  wire rd_hit_hi = haddr[31:8] != '0; // anything above the block reads zero
  wire [31:0] rd_word = rd_hit_hi ? 32'h00000000 :
                        (rd_addr == REG_CTRL) ? {30'h00000000, ctrl} :
                        (rd_addr == REG_SETPOINT) ? {22'h000000, setpoint} :
                        (rd_addr == REG_RATED) ? {16'h0000, rated_rpm} :
                        (rd_addr == REG_STATUS) ? status_word :
                        (rd_addr == REG_SPEED) ? {16'h0000, spd_q} : 32'h00000000;

  // bus handshake: zero wait states, always okay, read data set at address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= wr_take & (haddr[31:8] == '0);
      wr_addr <= haddr[7:0];
      if (rd_take)
        hrdata <= rd_word;
    end
  end

  // register contents; the setpoint survives stop and restart
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= CTRL_RST;
      setpoint <= SETPOINT_RST;
      rated_rpm <= RATED_RPM_RST;
      cmd_start <= 1'b0;
      cmd_stop <= 1'b0;
    end
    else
    begin
      cmd_start <= wr_cmd & hwdata[CMD_START_BIT];
      cmd_stop <= wr_cmd & hwdata[CMD_STOP_BIT];
      if (wr_ctrl)
        ctrl <= hwdata[1:0];
      if (wr_setpoint & pm_ok)
        setpoint <= wr_pm;
      if (wr_rated)
        rated_rpm <= hwdata[SPEED_W-1:0];
    end
  end

  // ****************************************************************
  // remote connector inputs
  // ****************************************************************
  logic [2:0] pin_s1; // first synchroniser stage, read by pin_s2 only
  logic [2:0] pin_s2; // settled pin levels
  logic [2:0] pin_d; // previous settled levels for edge detection

  // two-stage synchroniser for the connector pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_d <= 3'h0;
    end
    else
    begin
      pin_s1 <= {remote_reduced_select, remote_stop, remote_start};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  // local mode takes commands from registers, remote mode from the pins
  wire local_mode = ctrl[CTRL_LOCAL_BIT];
  wire start_evt = local_mode ? cmd_start : (pin_s2[0] & ~pin_d[0]);
  wire stop_evt = local_mode ? cmd_stop : (pin_s2[1] & ~pin_d[1]);
  // reduced select held as a level
  wire reduced_sel = local_mode ? ctrl[CTRL_REDUCED_BIT] : pin_s2[2];

  // ****************************************************************
  // target and threshold
  // ****************************************************************
  logic [SPEED_W-1:0] reduced_rpm;
  logic [SPEED_W-1:0] target_rpm;
  logic [SPEED_W-1:0] thr_rpm;
  logic reduced_above80; // setpoint above 80 percent of rated
  logic target_moved; // target changed last cycle

  psms_target u_target (
    .hclk(hclk),
    .hresetn(hresetn),
    .rated_rpm(rated_rpm),
    .setpoint(setpoint),
    .reduced_sel(reduced_sel),
    .reduced_rpm(reduced_rpm),
    .target_rpm(target_rpm),
    .thr_rpm(thr_rpm),
    .reduced_above80(reduced_above80),
    .target_moved(target_moved)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      spd_q <= '0;
    else
      spd_q <= measured_speed;
  end

  wire spd_above = spd_q > target_rpm;
  wire spd_below = spd_q < target_rpm;
  wire spd_thr = spd_q >= thr_rpm;
  wire spd_stopped = spd_q <= STOP_RPM;

  // ****************************************************************
  // sequencer state machine
  // ****************************************************************
  // next state; stop wins over every other request
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (start_evt & ~stop_evt)
          next_state = ST_ACCEL; // start accelerates
      ST_ACCEL:
        if (stop_evt)
          next_state = ST_STOPPING;
        // late reduced select brakes above setpoint
        else if (spd_above & reduced_sel & ~target_moved)
          next_state = ST_DECEL;
        else if (~spd_below & ~target_moved)
          next_state = ST_HOLD;
      ST_HOLD:
        if (stop_evt)
          next_state = ST_STOPPING;
        // besides stop, only a target change leaves hold, so ripple is regulated in place
        else if (target_moved & spd_above)
          next_state = ST_DECEL;
        else if (target_moved & spd_below)
          next_state = ST_ACCEL;
      ST_DECEL:
        if (stop_evt)
          next_state = ST_STOPPING;
        else if (~reduced_sel)
          next_state = ST_ACCEL;
        else if (~spd_above & ~target_moved)
          next_state = ST_HOLD;
      ST_STOPPING:
        if (start_evt & ~stop_evt)
          next_state = ST_ACCEL;
        else if (spd_stopped)
          next_state = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // status outputs
  // ****************************************************************
  logic next_acc;
  logic next_slow;
  logic next_at;
  wire from_hold_up = (state == ST_HOLD) & (next_state == ST_ACCEL);

  // status flags follow the transitions; hold to accel with reduced select or a setpoint above 80 percent keeps them as they are
  always_comb
  begin
    next_acc = speeding_up_output;
    next_slow = slowing_output;
    next_at = at_speed_output;
    if (next_state == ST_STOPPING | next_state == ST_DECEL)
    begin
      next_acc = 1'b0;
      next_at = 1'b0;
      next_slow = 1'b1;
    end
    else if (next_state == ST_IDLE)
      next_slow = 1'b0;
    else if (next_state == ST_HOLD)
    begin
      next_acc = 1'b0;
      next_slow = 1'b0;
      next_at = 1'b1;
    end
    else if (state == ST_IDLE | state == ST_STOPPING | state == ST_DECEL)
    begin
      next_slow = 1'b0;
      next_acc = ~spd_thr;
      next_at = spd_thr;
    end
    else if (from_hold_up & ~reduced_sel & ~reduced_above80)
    begin
      next_acc = 1'b1;
      next_at = 1'b0;
    end
    else if (state == ST_ACCEL & speeding_up_output & spd_thr & ~target_moved)
    begin
      next_acc = 1'b0;
      next_at = 1'b1;
    end
  end

  wire run_state = (state == ST_ACCEL) | (state == ST_HOLD) | (state == ST_DECEL);
  wire next_moving = (next_state == ST_ACCEL) | (next_state == ST_DECEL);
  wire next_hold = next_state == ST_HOLD;
  logic [31:0] spin_cnt; // cycles since start, until rotation flag

  // state, flags and motor commands
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ST_IDLE;
      speeding_up_output <= 1'b0;
      slowing_output <= 1'b0;
      at_speed_output <= 1'b0;
      speed_changing_marker <= 1'b0;
      motor_accel <= 1'b0;
      motor_brake <= 1'b0;
    end
    else
    begin
      state <= next_state;
      speeding_up_output <= next_acc;
      slowing_output <= next_slow;
      at_speed_output <= next_at;
      // marker while moving in reduced mode
      speed_changing_marker <= reduced_sel & next_moving;
      motor_accel <= (next_state == ST_ACCEL) | (next_hold & spd_below);
      motor_brake <= (next_state == ST_DECEL) | (next_state == ST_STOPPING)
                     | (next_hold & spd_above);
    end
  end

  // display, lamp and rotation flag
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_display <= DISP_STOP;
      speeding_up_display <= 1'b0;
      at_speed_lamp <= 1'b0;
      spinning_output <= 1'b0;
      spin_cnt <= 32'h00000000;
    end
    else
    begin
      op_display <= (next_state == ST_IDLE) ? DISP_STOP :
                    (next_slow) ? DISP_BRAKE :
                    (next_acc) ? DISP_ACC : DISP_NORMAL;
      speeding_up_display <= next_acc;
      at_speed_lamp <= at_speed_output;
      if (state == ST_IDLE)
        spin_cnt <= 32'h00000000;
      else if (run_state & ~spinning_output & (spin_cnt != SPIN_LAST))
        spin_cnt <= spin_cnt + 32'h00000001;
      if (run_state & ~spinning_output & (spin_cnt == SPIN_LAST))
        spinning_output <= 1'b1;
      else if ((state == ST_STOPPING | state == ST_IDLE) & spd_stopped)
        spinning_output <= 1'b0;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_start_accel;
    state == ST_IDLE && start_evt && !stop_evt |=> state == ST_ACCEL ##0 motor_accel;
  endproperty
  a_start_accel: assert property (p_start_accel) else $error("start did not accelerate");

  property p_spin_delay;
    $rose(spinning_output) |-> $past(spin_cnt) == SPIN_LAST;
  endproperty
  a_spin_delay: assert property (p_spin_delay) else $error("rotation flag early");

  property p_thr_reach;
    state == ST_ACCEL && speeding_up_output && spd_thr && !target_moved && !stop_evt
      && !(spd_above && reduced_sel) |=> !speeding_up_output && at_speed_output;
  endproperty
  a_thr_reach: assert property (p_thr_reach) else $error("threshold missed");

  property p_reach_hold;
    state == ST_ACCEL && spd_q == target_rpm && !target_moved && !stop_evt
      |=> state == ST_HOLD && !motor_accel;
  endproperty
  a_reach_hold: assert property (p_reach_hold) else $error("target not held");

  property p_decel_entry;
    state == ST_HOLD && target_moved && spd_above && !stop_evt
      |=> slowing_output && !at_speed_output && motor_brake;
  endproperty
  a_decel_entry: assert property (p_decel_entry) else $error("no braking");

  property p_decel_done;
    state == ST_DECEL && reduced_sel && !spd_above && !target_moved && !stop_evt
      |=> state == ST_HOLD && at_speed_output && !slowing_output;
  endproperty
  a_decel_done: assert property (p_decel_done) else $error("setpoint not held");

  property p_abandon;
    state == ST_DECEL && !reduced_sel && !stop_evt |=> state == ST_ACCEL && !slowing_output;
  endproperty
  a_abandon: assert property (p_abandon) else $error("slowdown not abandoned");

  property p_low_up;
    from_hold_up && !stop_evt && !reduced_sel && !reduced_above80
      |=> speeding_up_output && !at_speed_output;
  endproperty
  a_low_up: assert property (p_low_up) else $error("no speeding up");

  property p_high_up;
    from_hold_up && !reduced_sel && reduced_above80 |=> $stable(at_speed_output)
      && $stable(speeding_up_output) && $stable(slowing_output);
  endproperty
  a_high_up: assert property (p_high_up) else $error("status changed");

  property p_marker_clear;
    !reduced_sel |=> !speed_changing_marker;
  endproperty
  a_marker_clear: assert property (p_marker_clear) else $error("marker kept");

  property p_lamp_after;
    $fell(at_speed_output) && op_display == DISP_BRAKE |-> at_speed_lamp ##1 !at_speed_lamp;
  endproperty
  a_lamp_after: assert property (p_lamp_after) else $error("lamp order wrong");

  property p_setpoint_range;
    (setpoint >= PM_MIN && setpoint <= PM_FULL) and (!wr_setpoint |=> $stable(setpoint));
  endproperty
  a_setpoint_range: assert property (p_setpoint_range) else $error("bad setpoint");

  property p_spin_off;
    spinning_output && state == ST_STOPPING && spd_stopped && !start_evt |=> !spinning_output;
  endproperty
  a_spin_off: assert property (p_spin_off) else $error("rotation flag kept");

  c_reduced_start: cover property (state == ST_ACCEL && reduced_sel ##1 state == ST_HOLD);
  c_slow_down: cover property (state == ST_DECEL ##1 state == ST_HOLD);
  c_back_to_rated: cover property (from_hold_up && !reduced_sel);
  c_stop_done: cover property (state == ST_STOPPING ##1 state == ST_IDLE);

endmodule // psms_sequencer

// ===== tb/psms_host.sv
// host equipment model driving the remote-control pins of the sequencer
`timescale 1ns/100ps
module psms_host
(
  input wire logic hclk,
  output logic remote_start,
  output logic remote_stop,
  output logic remote_reduced_select
);
  // pins rest low until the host acts
  initial
  begin
    remote_start = 1'b0;
    remote_stop = 1'b0;
    remote_reduced_select = 1'b0;
  end
  // start or stop pulse, held long enough for the pin synchroniser
  task automatic press(input logic stop);
    @(posedge hclk);
    remote_start <= !stop;
    remote_stop <= stop;
    repeat (4) @(posedge hclk);
    remote_start <= 1'b0;
    remote_stop <= 1'b0;
  endtask
  task automatic hold_reduced(input logic on);
    @(posedge hclk);
    remote_reduced_select <= on;
  endtask
endmodule // psms_host

// ===== tb/pump_speed_mode_sequencer_test.sv
// self-checking bench for the pump speed-mode sequencer
`timescale 1ns/100ps
module pump_speed_mode_sequencer_test;
  import psms_pkg::*;
  // ************
  // bench state
  // ************
  logic hclk, hresetn, hsel, hwrite, hreadyout, rd_dp, motor_accel, motor_brake;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [SPEED_W-1:0] measured_speed, tgt;
  logic remote_start, remote_stop, remote_reduced_select;
  logic hresp, speeding_up_output, slowing_output, at_speed_output, spinning_output;
  logic at_speed_lamp, speed_changing_marker, speeding_up_display;
  psms_disp_e op_display, exp_disp; // display as shown, and as the flags imply
  logic [9:0] sp;
  logic [63:0] e;
  logic [63:0] exp_q[$]; // mask and expected value per read
  int num_errors = 0;
  int compares = 0;

  psms_sequencer #(.SPIN_DELAY(20)) i_psms_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .measured_speed(measured_speed),
    .remote_start(remote_start), .remote_stop(remote_stop),
    .remote_reduced_select(remote_reduced_select), .speeding_up_output(speeding_up_output),
    .slowing_output(slowing_output), .at_speed_output(at_speed_output),
    .spinning_output(spinning_output), .at_speed_lamp(at_speed_lamp),
    .speed_changing_marker(speed_changing_marker), .speeding_up_display(speeding_up_display),
    .op_display(op_display), .motor_accel(motor_accel), .motor_brake(motor_brake));
  psms_host i_psms_host (.hclk(hclk), .remote_start(remote_start),
    .remote_stop(remote_stop), .remote_reduced_select(remote_reduced_select));

  // 125 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // rotor: 30 rpm a cycle keeps every setpoint target an exact multiple
  always @(posedge hclk)
    if (motor_accel) measured_speed <= measured_speed + 16'h001e;
    else if (motor_brake && measured_speed >= 16'h001e) measured_speed <= measured_speed - 16'h001e;
  // watcher: each completed read data phase takes the oldest note
  always @(posedge hclk)
    if (rd_dp && hreadyout && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      compares++;
      if ((hrdata & e[63:32]) !== e[31:0])
      begin
        num_errors++;
        $display("wrong value at %0t: read %h expected %h", $time, hrdata, e[31:0]);
      end
      // settled flags fix what the display, the lamp and the response show
      exp_disp = slowing_output ? DISP_BRAKE : speeding_up_output ? DISP_ACC :
                 at_speed_output ? DISP_NORMAL : DISP_STOP;
      if (hresp !== 1'b0 || at_speed_lamp !== at_speed_output || op_display !== exp_disp)
      begin
        num_errors++;
        $display("wrong value at %0t: lamp, display or response", $time);
      end
      if (speeding_up_display !== speeding_up_output)
      begin
        num_errors++;
        $display("wrong value at %0t: speeding-up display", $time);
      end
    end
  // hang guard, well beyond the longest ramp sequence
  initial
  begin
    #400000;
    num_errors++;
    stop_test();
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // one single-word transfer; a read notes its expected value first
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    if (!w) exp_q.push_back({m, d});
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    rd_dp <= 1'b0;
  endtask
  // wait until the rotor passes a speed, then let the status settle
  task automatic wait_speed(input logic [SPEED_W-1:0] v, input logic up);
    for (int n = 0; n < 5000; n++)
      if (up ? measured_speed < v : measured_speed > v) @(posedge hclk);
    repeat (8) @(posedge hclk);
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // main sequence: remote runs first, then local runs with random setpoints
  initial
  begin
    {hresetn, hsel, hwrite, rd_dp, haddr, hwdata, htrans, measured_speed} = '0;
    hsize = HSIZE_WORD;
    rnd = 32'hd0fe4fe6;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, REG_SETPOINT, 32'h1f4, 32'hffffffff);
    ahb(0, 8'h20, 32'h0, 32'hffffffff);
    ahb(1, REG_SETPOINT, 32'h64, 32'h0);
    ahb(0, REG_SETPOINT, 32'h1f4, 32'hffffffff);
    i_psms_host.hold_reduced(1'b1);
    i_psms_host.press(1'b0);
    wait_speed(16'h0bb8, 1'b1);
    ahb(0, REG_STATUS, 32'h156, 32'h7ff);
    wait_speed(16'h3a98, 1'b1);
    ahb(0, REG_STATUS, 32'h230, 32'h7f3);
    i_psms_host.hold_reduced(1'b0);
    wait_speed(16'h3bc4, 1'b1);
    ahb(0, REG_STATUS, 32'h154, 32'h7ff);
    wait_speed(16'h6018, 1'b1);
    ahb(0, REG_STATUS, 32'h134, 32'h7ff);
    wait_speed(16'h7530, 1'b1);
    ahb(0, REG_STATUS, 32'h230, 32'h7f3);
    i_psms_host.hold_reduced(1'b1);
    wait_speed(16'h7148, 1'b0);
    ahb(0, REG_STATUS, 32'h39a, 32'h7ff);
    i_psms_host.hold_reduced(1'b0);
    wait_speed(16'h72d8, 1'b1);
    ahb(0, REG_STATUS, 32'h134, 32'h7ff);
    wait_speed(16'h7530, 1'b1);
    i_psms_host.hold_reduced(1'b1);
    wait_speed(16'h3a98, 1'b0);
    ahb(0, REG_STATUS, 32'h230, 32'h7f3);
    ahb(1, REG_CTRL, 32'h3, 32'h0);
    i_psms_host.hold_reduced(1'b0);
    // first setpoint above 80 percent, second at or below it
    for (int i = 0; i < 2; i++)
    begin
      rnd = lfsr(rnd);
      // second setpoint kept clear of 80 percent so the ramp is still below it when read
      sp = (i == 0) ? 10'h321 + 10'(rnd % 199) : 10'h0fa + 10'(rnd % 500);
      tgt = 16'(sp * 30);
      ahb(1, REG_CTRL, 32'h3, 32'h0);
      ahb(1, REG_SETPOINT, {22'h0, sp}, 32'h0);
      wait_speed(tgt, tgt > measured_speed);
      ahb(0, REG_SETPOINT, {22'h0, sp}, 32'h3ff);
      ahb(0, REG_STATUS, 32'h231, 32'h7f3);
      ahb(1, REG_CTRL, 32'h1, 32'h0);
      repeat (8) @(posedge hclk);
      if (i == 0) ahb(0, REG_STATUS, 32'h031, 32'h0f3);
      else ahb(0, REG_STATUS, 32'h155, 32'h7ff);
      wait_speed(16'h7530, 1'b1);
      ahb(0, REG_STATUS, 32'h231, 32'h7f3);
    end
    ahb(1, REG_CMD, 32'h2, 32'h0);
    wait_speed(16'h003c, 1'b0);
    ahb(0, REG_STATUS, 32'h001, 32'h7ff);
    stop_test();
  end
endmodule // pump_speed_mode_sequencer_test
